// >>> include/osc_switch_defs.vh
// register offsets, field positions, reset values and codes for the oscillator switch block
// assumes inclusion by bare name from design and bench files
`ifndef OSC_SWITCH_DEFS_VH
`define OSC_SWITCH_DEFS_VH

`define OSC_ADDR_W 12
`define OSC_REQUEST_OFS 12'h88D
`define OSC_CURRENT_OFS 12'h88E
`define OSC_SWCTL_OFS 12'h88F
`define OSC_STATUS_OFS 12'h890
`define OSC_ENABLE_OFS 12'h891
`define OSC_TRIM_OFS 12'h892
`define OSC_FREQ_OFS 12'h893

// request and current field positions
`define OSC_SRC_MSB 6
`define OSC_SRC_LSB 4
`define OSC_DIV_MSB 3
`define OSC_DIV_LSB 0

// switch control bit positions
`define OSC_HOLD_BIT 7
`define OSC_SPWR_BIT 6
`define OSC_DONE_BIT 4
`define OSC_NSR_BIT 3

// source codes
`define OSC_SRC_EXT 3'h7
`define OSC_SRC_FAST 3'h6
`define OSC_SRC_SLOW 3'h5
`define OSC_SRC_SEC 3'h4
`define OSC_SRC_RSV_HI 3'h3
`define OSC_SRC_EXT_PLL 3'h2
`define OSC_SRC_FAST_PLL 3'h1
`define OSC_SRC_RSV_LO 3'h0

// divider codes
`define OSC_DIV_MAX 4'h9
`define OSC_DIV_RESET_FAST 4'h2
`define OSC_DIV_RESET_OTHER 4'h0

// reset values
`define OSC_SWCTL_RESET 2'h0
`define OSC_ENABLE_RESET 6'h00
`define OSC_TRIM_RESET 6'h00
`define OSC_FREQ_RESET 3'h0

`endif

// >>> hw/osc_switch_ctrl.v
// oscillator control register bank and clock-switch sequencer
// assumes inputs synchronous to i_sys_clk; oscillator ready inputs are levels from the analog side
// What this block does
// - source codes decode to oscillator and multiplier
// - divider code selects ratio two power code
// - reserved source write leaves source unchanged
// - fuse zero makes request register read-only
// - reset loads requested source from fuse
// - reset divider 0010 for fast, else 0000
// - active source and divider are read-only
// - active fields equal request after reset
// - held switch waits, raises switch interrupt flag
// - unheld switch happens once new source ready and both clocks safe
// - secondary power select bit, resets low
// - done flag high when request equals active
// - new-source-ready only during switch with ready
// - unheld new-source-ready lasts one cycle when both clocks are safe, longer while either is not
// - external ready in status bit seven
// - switch interrupt flag set with new-source-ready
// - switch updates active fields, clears ready flag
// - force-on bits keep oscillators running, reset low
`timescale 1ns/1ps
`include "osc_switch_defs.vh"

module osc_switch_ctrl #(
	parameter SRC_W = 3,
	parameter DIV_W = 4
) (
	input wire i_sys_clk,
	input wire i_srst,
	input wire [11:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire [2:0] i_reset_source_fuse,
	input wire i_switch_permit_fuse,
	input wire i_external_ready,
	input wire i_fast_internal_ready,
	input wire i_mid_internal_ready,
	input wire i_slow_internal_ready,
	input wire i_secondary_ready,
	input wire i_converter_clock_ready,
	input wire i_multiplier_ready,
	input wire i_old_clock_safe,
	input wire i_new_clock_safe,
	input wire i_peripheral_request_ext,
	input wire i_peripheral_request_fast,
	input wire i_peripheral_request_mid,
	input wire i_peripheral_request_slow,
	input wire i_peripheral_request_sec,
	input wire i_peripheral_request_conv,
	input wire i_switch_irq_enable,
	output reg [2:0] o_active_source,
	output reg [3:0] o_active_divider,
	output reg [9:0] o_divide_ratio,
	output reg o_multiplier_on,
	output wire o_switch_pending,
	output wire o_switch_irq_flag,
	output wire o_switch_irq,
	output wire o_secondary_high_power,
	output wire o_external_run,
	output wire o_fast_internal_run,
	output wire o_mid_internal_run,
	output wire o_slow_internal_run,
	output wire o_secondary_run,
	output wire o_converter_clock_run,
	output wire [5:0] o_fast_internal_trim,
	output wire [2:0] o_fast_internal_freq_select
);

	// default divider for a given source at reset
	function [3:0] reset_divider;
		input [2:0] src;
		begin
			reset_divider = (src == `OSC_SRC_FAST) ? `OSC_DIV_RESET_FAST : `OSC_DIV_RESET_OTHER;
		end
	endfunction

	// reserved source codes
	function is_reserved_source;
		input [2:0] src;
		begin
			is_reserved_source = (src == `OSC_SRC_RSV_HI) || (src == `OSC_SRC_RSV_LO);
		end
	endfunction

	// sources that run through the clock multiplier
	function is_pll_source;
		input [2:0] src;
		begin
			is_pll_source = (src == `OSC_SRC_EXT_PLL) || (src == `OSC_SRC_FAST_PLL);
		end
	endfunction

	// ready level of the oscillator chain behind a source code
	function source_ready;
		input [2:0] src;
		input ext_r;
		input fast_r;
		input slow_r;
		input sec_r;
		input pll_r;
		begin
			case (src)
			`OSC_SRC_EXT: source_ready = ext_r;
			`OSC_SRC_FAST: source_ready = fast_r;
			`OSC_SRC_SLOW: source_ready = slow_r;
			`OSC_SRC_SEC: source_ready = sec_r;
			`OSC_SRC_EXT_PLL: source_ready = ext_r & pll_r;
			`OSC_SRC_FAST_PLL: source_ready = fast_r & pll_r;
			default: source_ready = 1'b0;
			endcase
		end
	endfunction

	// postscaler ratio, two to the power of the code; reserved codes give zero
	function [9:0] ratio_of;
		input [3:0] div;
		begin
			if (div <= `OSC_DIV_MAX) begin
				ratio_of = 10'h001 << div;
			end else begin
				ratio_of = 10'h000;
			end
		end
	endfunction

	// sequencer states
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_HELD = 2'h2;
	localparam ST_SWAP = 2'h3;

	// sequencer and register state
	reg [1:0] state;
	reg [1:0] next_state;
	reg [2:0] requested_source;
	reg [3:0] requested_divider;
	reg switch_hold;
	reg secondary_power_select;
	reg new_source_ready;
	reg switch_irq_flag;
	reg [5:0] force_on;
	reg [5:0] fast_internal_trim;
	reg [2:0] fast_internal_freq_select;
	reg reset_seen;
	reg [7:0] next_rdata;

	// switch status and write field slices
	wire mismatch;
	wire req_ready;
	wire switch_done_flag;
	wire do_swap;
	wire [2:0] wr_source;
	wire [3:0] wr_divider;
	// register hits for the write strobe
	wire wr_request;
	wire wr_swctl;
	wire wr_enable;
	wire wr_trim;
	wire wr_freq;

	assign mismatch = (requested_source != o_active_source) || (requested_divider != o_active_divider);
	assign switch_done_flag = ~mismatch;
	assign req_ready = source_ready(requested_source, i_external_ready, i_fast_internal_ready,
		i_slow_internal_ready, i_secondary_ready, i_multiplier_ready);
	// swap in the swap state whenever both clocks sit at a safe level; switch_hold is not checked here
	assign do_swap = (state == ST_SWAP) && i_old_clock_safe && i_new_clock_safe;
	assign wr_source = i_wdata[`OSC_SRC_MSB:`OSC_SRC_LSB];
	assign wr_divider = i_wdata[`OSC_DIV_MSB:`OSC_DIV_LSB];

	// write decode, one hit per writable register
	assign wr_request = i_wr && (i_addr == `OSC_REQUEST_OFS);
	assign wr_swctl = i_wr && (i_addr == `OSC_SWCTL_OFS);
	assign wr_enable = i_wr && (i_addr == `OSC_ENABLE_OFS);
	assign wr_trim = i_wr && (i_addr == `OSC_TRIM_OFS);
	assign wr_freq = i_wr && (i_addr == `OSC_FREQ_OFS);

	// switch sequencer next state
	// a rewrite to the active value abandons a pending or held switch
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (mismatch) begin
				next_state = ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (!mismatch) begin
				next_state = ST_IDLE;
			end else if (req_ready && switch_hold) begin
				next_state = ST_HELD;
			end else if (req_ready) begin
				next_state = ST_SWAP;
			end
		end
		ST_HELD: begin
			if (!mismatch) begin
				next_state = ST_IDLE;
			end else if (!req_ready) begin
				next_state = ST_WAIT;
			end else if (!switch_hold) begin
				next_state = ST_SWAP;
			end
		end
		ST_SWAP: begin
			if (do_swap || !mismatch) begin
				next_state = ST_IDLE;
			end else if (!req_ready) begin
				next_state = ST_WAIT;
			end else if (switch_hold) begin
				next_state = ST_HELD;
			end
		end
		default: next_state = ST_IDLE;
		endcase
	end

	// request register, fuse-loaded at reset
	// reserved source codes leave the source alone, the divider still lands
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			requested_source <= i_reset_source_fuse;
			requested_divider <= reset_divider(i_reset_source_fuse);
		end else if (wr_request && i_switch_permit_fuse) begin
			if (!is_reserved_source(wr_source)) begin
				requested_source <= wr_source;
			end
			requested_divider <= wr_divider;
		end
	end

	// active fields follow request at reset and at the swap instant
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_active_source <= i_reset_source_fuse;
			o_active_divider <= reset_divider(i_reset_source_fuse);
		end else if (do_swap) begin
			o_active_source <= requested_source;
			o_active_divider <= requested_divider;
		end
	end

	// decoded clock tree controls from the active selection
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_divide_ratio <= 10'h000;
			o_multiplier_on <= 1'b0;
		end else begin
			o_divide_ratio <= ratio_of(o_active_divider);
			o_multiplier_on <= is_pll_source(o_active_source);
		end
	end

	// sequencer state and new-source-ready flag
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			state <= ST_IDLE;
			new_source_ready <= 1'b0;
		end else begin
			state <= next_state;
			// high only in a switch with ready source, dropped at the swap
			new_source_ready <= (next_state == ST_HELD) || ((next_state == ST_SWAP) && !do_swap);
		end
	end

	// sticky switch interrupt flag; set wins over software clear
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			switch_irq_flag <= 1'b0;
		end else if ((state == ST_WAIT) && mismatch && req_ready) begin
			switch_irq_flag <= 1'b1;
		end else if (wr_swctl && !i_wdata[`OSC_DONE_BIT]) begin
			switch_irq_flag <= 1'b0;
		end
	end

	// switch control bits
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			{switch_hold, secondary_power_select} <= `OSC_SWCTL_RESET;
		end else if (wr_swctl) begin
			switch_hold <= i_wdata[`OSC_HOLD_BIT];
			secondary_power_select <= i_wdata[`OSC_SPWR_BIT];
		end
	end

	// manual oscillator enables
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			force_on <= `OSC_ENABLE_RESET;
		end else if (wr_enable) begin
			force_on <= i_wdata[7:2];
		end
	end

	// fast internal oscillator trim
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			fast_internal_trim <= `OSC_TRIM_RESET;
		end else if (wr_trim) begin
			fast_internal_trim <= i_wdata[5:0];
		end
	end

	// fast internal oscillator frequency select
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			fast_internal_freq_select <= `OSC_FREQ_RESET;
		end else if (wr_freq) begin
			fast_internal_freq_select <= i_wdata[2:0];
		end
	end

	// catches the first cycle after reset release; no source-driven oscillator run requests before it
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			reset_seen <= 1'b0;
		end else begin
			reset_seen <= 1'b1;
		end
	end

	// read mux for the addressed register
	always @* begin
		next_rdata = 8'h00;
		case (i_addr)
		`OSC_REQUEST_OFS: next_rdata = {1'b0, requested_source, requested_divider};
		`OSC_CURRENT_OFS: next_rdata = {1'b0, o_active_source, o_active_divider};
		`OSC_SWCTL_OFS: next_rdata = {switch_hold, secondary_power_select, 1'b0, switch_done_flag,
			new_source_ready, 3'h0};
		`OSC_STATUS_OFS: next_rdata = {i_external_ready, i_fast_internal_ready, i_mid_internal_ready,
			i_slow_internal_ready, i_secondary_ready, i_converter_clock_ready, 1'b0, i_multiplier_ready};
		`OSC_ENABLE_OFS: next_rdata = {force_on, 2'h0};
		`OSC_TRIM_OFS: next_rdata = {2'h0, fast_internal_trim};
		`OSC_FREQ_OFS: next_rdata = {5'h00, fast_internal_freq_select};
		default: next_rdata = 8'h00;
		endcase
	end

	// read data, valid in the cycle after the read strobe and zero otherwise
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// oscillator run requests: forced, peripheral, or selected by the requested source
	assign o_external_run = force_on[5] | i_peripheral_request_ext | (reset_seen &
		((requested_source == `OSC_SRC_EXT) | (requested_source == `OSC_SRC_EXT_PLL)));
	assign o_fast_internal_run = force_on[4] | i_peripheral_request_fast | (reset_seen &
		((requested_source == `OSC_SRC_FAST) | (requested_source == `OSC_SRC_FAST_PLL)));
	assign o_mid_internal_run = force_on[3] | i_peripheral_request_mid;
	assign o_slow_internal_run = force_on[2] | i_peripheral_request_slow | (reset_seen &
		(requested_source == `OSC_SRC_SLOW));
	assign o_secondary_run = force_on[1] | i_peripheral_request_sec | (reset_seen &
		(requested_source == `OSC_SRC_SEC));
	assign o_converter_clock_run = force_on[0] | i_peripheral_request_conv;

	// status and control outputs
	assign o_switch_pending = mismatch;
	assign o_switch_irq_flag = switch_irq_flag;
	assign o_switch_irq = switch_irq_flag & i_switch_irq_enable;
	assign o_secondary_high_power = secondary_power_select;
	assign o_fast_internal_trim = fast_internal_trim;
	assign o_fast_internal_freq_select = fast_internal_freq_select;

endmodule // osc_switch_ctrl

// >>> dv/osc_switch_ctrl_assertions.sv
// port-level timing checks for the oscillator switch block
// assumes binding onto osc_switch_ctrl, one clock, synchronous reset
`timescale 1ns/1ps
module osc_switch_ctrl_assertions (
	input wire i_sys_clk,
	input wire i_srst,
	input wire [11:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_old_clock_safe,
	input wire i_new_clock_safe,
	input wire i_switch_irq_enable,
	input wire [2:0] o_active_source,
	input wire [3:0] o_active_divider,
	input wire [9:0] o_divide_ratio,
	input wire o_multiplier_on,
	input wire o_switch_pending,
	input wire o_switch_irq_flag,
	input wire o_switch_irq,
	input wire o_secondary_high_power
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// interrupt and flag relations
	chk_irq_gate: assert property (
		o_switch_irq == (o_switch_irq_flag && i_switch_irq_enable)) else $error("irq not flag and enable");
	chk_flag_in_switch: assert property (
		$rose(o_switch_irq_flag) |-> o_switch_pending) else $error("flag raised outside a switch");
	// active fields move only at a swap
	chk_active_hold: assert property (
		!o_switch_pending |=> $stable(o_active_source) && $stable(o_active_divider)) else $error("active moved idle");
	chk_swap_clears: assert property (
		!$past(i_srst) && ($changed(o_active_source) || $changed(o_active_divider)) |-> !o_switch_pending)
		else $error("swap left switch pending");
	chk_safe_gate: assert property (
		!i_srst && !(i_old_clock_safe && i_new_clock_safe) |=> $stable(o_active_source))
		else $error("swap at unsafe point");
	// derived outputs one cycle behind the active fields, power select one cycle after its write
	chk_ratio: assert property (
		!$past(i_srst) |-> o_divide_ratio == ($past(o_active_divider) > 4'h9 ? 10'h000 :
		10'h001 << $past(o_active_divider))) else $error("divide ratio wrong");
	chk_pll_flag: assert property (
		!$past(i_srst) |-> o_multiplier_on == ($past(o_active_source) == 3'h1 || $past(o_active_source) == 3'h2))
		else $error("multiplier flag wrong");
	chk_power_write: assert property (
		!i_srst && i_wr && i_addr == 12'h88F |=> o_secondary_high_power == $past(i_wdata[6]))
		else $error("power select not written");
endmodule // osc_switch_ctrl_assertions

bind osc_switch_ctrl osc_switch_ctrl_assertions u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_old_clock_safe(i_old_clock_safe), .i_new_clock_safe(i_new_clock_safe),
	.i_switch_irq_enable(i_switch_irq_enable), .o_active_source(o_active_source),
	.o_active_divider(o_active_divider), .o_divide_ratio(o_divide_ratio), .o_multiplier_on(o_multiplier_on),
	.o_switch_pending(o_switch_pending), .o_switch_irq_flag(o_switch_irq_flag), .o_switch_irq(o_switch_irq),
	.o_secondary_high_power(o_secondary_high_power));

// >>> dv/oscillator_switch_control_test.sv
// register-level testbench for the oscillator switch block
// assumes the checker is bound separately; bench drives all ports itself
`timescale 1ns/1ps
module oscillator_switch_control_test;
	logic i_sys_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, perm = 1, os = 1, ns = 1, ien = 1;
	logic [11:0] i_addr = 0;
	logic [7:0] i_wdata = 0;
	logic [2:0] fuse = 3'h6;
	logic [6:0] rdy = 7'h7F;
	logic [5:0] pq = 6'h00;
	logic [6:0] t [6] = '{7'h79, 7'h60, 7'h41, 7'h25, 7'h13, 7'h50};
	int n_fail = 0, compares = 0;
	wire [7:0] o_rdata;
	wire [2:0] asrc;
	wire [9:0] ratio;
	wire mult, pend, flag, irq, hp, srun, erun, frun, mrun, lrun, crun;
	wire [3:0] adiv;
	wire [5:0] trim;
	wire [2:0] fsel;
	osc_switch_ctrl uut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_reset_source_fuse(fuse), .i_switch_permit_fuse(perm),
		.i_external_ready(rdy[6]), .i_fast_internal_ready(rdy[5]), .i_mid_internal_ready(rdy[4]),
		.i_slow_internal_ready(rdy[3]), .i_secondary_ready(rdy[2]), .i_converter_clock_ready(rdy[1]),
		.i_multiplier_ready(rdy[0]), .i_old_clock_safe(os), .i_new_clock_safe(ns),
		.i_peripheral_request_ext(pq[5]), .i_peripheral_request_fast(pq[4]), .i_peripheral_request_mid(pq[3]),
		.i_peripheral_request_slow(pq[2]), .i_peripheral_request_sec(pq[1]), .i_peripheral_request_conv(pq[0]),
		.i_switch_irq_enable(ien), .o_active_source(asrc), .o_active_divider(adiv), .o_divide_ratio(ratio),
		.o_multiplier_on(mult), .o_switch_pending(pend), .o_switch_irq_flag(flag), .o_switch_irq(irq),
		.o_secondary_high_power(hp), .o_external_run(erun), .o_fast_internal_run(frun), .o_mid_internal_run(mrun),
		.o_slow_internal_run(lrun), .o_secondary_run(srun), .o_converter_clock_run(crun),
		.o_fast_internal_trim(trim), .o_fast_internal_freq_select(fsel));
	// 125 MHz clock
	always #4 i_sys_clk = ~i_sys_clk;
	// compare, bus cycles, waits
	task automatic ck(input string nm, input logic [9:0] s, input logic [9:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_sys_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= d; end
		@(posedge i_sys_clk) i_wr <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge i_sys_clk) begin i_rd <= 1; i_addr <= a; end
		@(posedge i_sys_clk) i_rd <= 0;
		#1 ck("rdata", o_rdata, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic rst(input logic [2:0] f);
		@(posedge i_sys_clk) begin i_srst <= 1; fuse <= f; end
		repeat (4) @(posedge i_sys_clk);
		i_srst <= 0;
	endtask
	task finish_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// watchdog
	initial begin
		#50000;
		n_fail++;
		finish_test;
	end
	// test sequence
	initial begin
		rst(3'h6);
		rd(12'h88D, 8'h62);
		rd(12'h88E, 8'h62);
		rd(12'h88F, 8'h10);
		rst(3'h5);
		rd(12'h88E, 8'h50);
		foreach (t[i]) begin
			wr(12'h88D, {1'b0, t[i]});
			cyc(4);
			ck("source", asrc, t[i][6:4]);
			ck("divider", adiv, t[i][3:0]);
			ck("ratio", ratio, 10'h001 << t[i][3:0]);
			ck("pll", mult, t[i][6:4] == 3'h1 || t[i][6:4] == 3'h2);
		end
		wr(12'h88D, 8'h33);
		cyc(4);
		rd(12'h88D, 8'h53);
		wr(12'h88D, 8'h01);
		cyc(4);
		rd(12'h88E, 8'h51);
		wr(12'h88E, 8'h00);
		rd(12'h88E, 8'h51);
		rd(12'h894, 8'h00);
		@(posedge i_sys_clk) rdy[2] <= 0;
		wr(12'h88D, 8'h40);
		cyc(6);
		ck("source", asrc, 3'h5);
		rd(12'h88F, 8'h00);
		@(posedge i_sys_clk) rdy[2] <= 1;
		cyc(4);
		ck("source", asrc, 3'h4);
		@(posedge i_sys_clk) os <= 0;
		wr(12'h88D, 8'h51);
		cyc(6);
		ck("source", asrc, 3'h4);
		@(posedge i_sys_clk) os <= 1;
		cyc(4);
		ck("source", asrc, 3'h5);
		wr(12'h88F, 8'h80);
		wr(12'h88D, 8'h70);
		cyc(5);
		ck("source", asrc, 3'h5);
		ck("flag", flag, 1'b1);
		rd(12'h88F, 8'h88);
		@(posedge i_sys_clk) ien <= 0;
		cyc(1);
		ck("irq", irq, 1'b0);
		@(posedge i_sys_clk) ien <= 1;
		wr(12'h88F, 8'h10);
		cyc(6);
		ck("source", asrc, 3'h7);
		ck("irq", irq, 1'b1);
		wr(12'h88F, 8'h00);
		cyc(1);
		ck("flag", flag, 1'b0);
		wr(12'h88F, 8'h80);
		wr(12'h88D, 8'h50);
		cyc(4);
		wr(12'h88D, 8'h70);
		cyc(1);
		ck("pending", pend, 1'b0);
		rd(12'h88F, 8'h90);
		wr(12'h88F, 8'h40);
		rd(12'h88F, 8'h50);
		ck("power", hp, 1'b1);
		@(posedge i_sys_clk) rdy <= 7'h3F;
		rd(12'h890, 8'h7D);
		@(posedge i_sys_clk) rdy <= 7'h7F;
		rd(12'h890, 8'hFD);
		wr(12'h891, 8'h08);
		rd(12'h891, 8'h08);
		ck("run", srun, 1'b1);
		wr(12'h891, 8'h00);
		cyc(1);
		ck("run", srun, 1'b0);
		ck("runs", {erun, frun, mrun, lrun, srun, crun}, 6'h20);
		wr(12'h891, 8'hFC);
		cyc(1);
		ck("runs", {erun, frun, mrun, lrun, srun, crun}, 6'h3F);
		wr(12'h891, 8'h00);
		cyc(1);
		@(posedge i_sys_clk) pq <= 6'h02;
		cyc(1);
		ck("run", srun, 1'b1);
		@(posedge i_sys_clk) perm <= 0;
		wr(12'h88D, 8'h50);
		rd(12'h88D, 8'h70);
		wr(12'h892, 8'h3F);
		rd(12'h892, 8'h3F);
		ck("trim", trim, 6'h3F);
		wr(12'h893, 8'h05);
		rd(12'h893, 8'h05);
		ck("freq", fsel, 3'h5);
		finish_test;
	end
endmodule // oscillator_switch_control_test
